// File: hw/store_cmd_defs.svh
`ifndef STORE_CMD_DEFS_SVH
`define STORE_CMD_DEFS_SVH

// ****************************************************************
// Geometry and addressing constants
// ****************************************************************
`define STORE_NUM_BLOCKS  16'h0077
`define STORE_BLOCK_BYTES 16'h0200
`define STORE_CLUSTER     16'h0023
`define STORE_ENDPOINT    8'he6
`define CMD_GEOMETRY_Q    8'h00
`define CMD_REPLY_BIT     8'h80
`define CMD_LAST_VALID    8'h04
`define STATUS_ERR_BIT    0
`define HDR_BYTES         4'h8
`endif

// File: hw/store_cmd_device.sv
`timescale 1ns/1ns
`include "store_cmd_defs.svh"
module store_cmd_device #(
    parameter int NUM_BLOCKS = 119
) (
    input  wire logic SYS_CLK_I,      // 25 MHz clock
    input  wire logic RESETN_I,       // Async reset, active low
    store_link_if.device LINK,        // Request and response streams
    output logic      FW_SLOT_BUSY_O, // Store holds a firmware image
    input  wire logic FW_SLOT_SET_I,  // Firmware image landed in store
    output logic      CMD_DONE_O      // Pulse per executed command
);
    initial begin
        if (NUM_BLOCKS < 1 || NUM_BLOCKS > 65535) $error("bad NUM_BLOCKS");
    end

    // ****************************************************************
    // Request capture
    // ****************************************************************
    store_cmd_pkg::xfer_state_t st_q, st_d;
    logic [7:0]  hdr_q [8];
    logic [7:0]  hdr_d [8];
    logic [3:0]  idx_q, idx_d;
    logic        bcast_q, bcast_d;
    logic [7:0]  ep_q, ep_d;
    logic        done_q, done_d;
    logic        fw_q, fw_d;
    logic [7:0]  obyte;
    logic        addr_ok;
    logic [15:0] blk;
    logic [7:0]  code;
    logic        err;
    logic [7:0]  rsp_code;

    // Only frames to the store cluster and endpoint are taken
    assign addr_ok = (LINK.req_cluster == `STORE_CLUSTER) &&
                     (LINK.req_dst_ep == `STORE_ENDPOINT);
    assign code = hdr_q[0];
    assign blk  = {hdr_q[2], hdr_q[3]};
    // Data bytes beyond the header are accepted and dropped; the read and write
    // paths are not in this block, so the store geometry answers only queries
    assign err = (code > `CMD_LAST_VALID) ||
                 (code != `CMD_GEOMETRY_Q && blk >= 16'(NUM_BLOCKS));
    assign rsp_code = code | `CMD_REPLY_BIT;

    // Response byte mux, most significant byte first
    always_comb begin
        obyte = 8'h00;
        case (idx_q[2:0])
            3'h0: obyte = rsp_code;
            3'h1: obyte = {7'h00, err};
            3'h2: obyte = (code == `CMD_GEOMETRY_Q) ? 8'(NUM_BLOCKS >> 8) : hdr_q[2];
            3'h3: obyte = (code == `CMD_GEOMETRY_Q) ? 8'(NUM_BLOCKS) : hdr_q[3];
            3'h4: obyte = (code == `CMD_GEOMETRY_Q) ? 8'(`STORE_BLOCK_BYTES >> 8) : hdr_q[4];
            3'h5: obyte = (code == `CMD_GEOMETRY_Q) ? 8'(`STORE_BLOCK_BYTES) : hdr_q[5];
            default: obyte = 8'h00;                                    // Count zero
        endcase
    end

    assign LINK.req_ready = (st_q != store_cmd_pkg::ST_WAIT);
    assign LINK.rsp_valid = (st_q == store_cmd_pkg::ST_WAIT);
    assign LINK.rsp_byte  = obyte;
    assign LINK.rsp_last  = (idx_q == 4'h7);
    assign LINK.rsp_dst_ep = ep_q;
    assign CMD_DONE_O     = done_q;
    assign FW_SLOT_BUSY_O = fw_q;

    // Next-state for framing, header capture and reply
    always_comb begin
        st_d = st_q;
        idx_d = idx_q;
        bcast_d = bcast_q;
        ep_d = ep_q;
        done_d = 1'b0;
        fw_d = fw_q | FW_SLOT_SET_I;
        for (int i = 0; i < 8; i++) hdr_d[i] = hdr_q[i];
        case (st_q)
            store_cmd_pkg::ST_IDLE,
            store_cmd_pkg::ST_HDR: begin
                if (LINK.req_valid && addr_ok) begin
                    if (idx_q < `HDR_BYTES) hdr_d[idx_q[2:0]] = LINK.req_byte;
                    if (idx_q < `HDR_BYTES) idx_d = idx_q + 4'h1;
                    bcast_d = LINK.req_bcast;
                    ep_d = LINK.req_src_ep;
                    st_d = store_cmd_pkg::ST_HDR;
                    if (LINK.req_last) begin
                        done_d = 1'b1;
                        idx_d = 4'h0;
                        // Broadcast is executed but silent
                        st_d = LINK.req_bcast ? store_cmd_pkg::ST_IDLE
                                              : store_cmd_pkg::ST_WAIT;
                    end
                end
            end
            store_cmd_pkg::ST_WAIT: begin
                if (LINK.rsp_ready) begin
                    idx_d = idx_q + 4'h1;
                    if (idx_q == 4'h7) begin
                        idx_d = 4'h0;
                        st_d = store_cmd_pkg::ST_IDLE;
                    end
                end
            end
            default: st_d = store_cmd_pkg::ST_IDLE;
        endcase
    end

    // Register stage
    always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            st_q <= store_cmd_pkg::ST_IDLE;
            idx_q <= 4'h0;
            bcast_q <= 1'b0;
            ep_q <= 8'h00;
            done_q <= 1'b0;
            fw_q <= 1'b0;
            for (int i = 0; i < 8; i++) hdr_q[i] <= 8'h00;
        end else begin
            st_q <= st_d;
            idx_q <= idx_d;
            bcast_q <= bcast_d;
            ep_q <= ep_d;
            done_q <= done_d;
            fw_q <= fw_d;
            for (int i = 0; i < 8; i++) hdr_q[i] <= hdr_d[i];
        end
    end
endmodule

// File: hw/store_cmd_pkg.sv
package store_cmd_pkg;
    // Byte-serial framing states shared by both ends
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_HDR,
        ST_WAIT
    } xfer_state_t;
endpackage

// File: hw/store_cmd_requester.sv
`timescale 1ns/1ns
`include "store_cmd_defs.svh"
module store_cmd_requester (
    input  wire logic        SYS_CLK_I,      // 25 MHz clock
    input  wire logic        RESETN_I,       // Async reset, active low
    store_link_if.requester  LINK,           // Request and response streams
    input  wire logic        START_I,        // Pulse: send one command
    input  wire logic [7:0]  CODE_I,         // Command code
    input  wire logic [15:0] BLOCK_I,        // Block index
    input  wire logic [15:0] OFFSET_I,       // Byte offset
    input  wire logic        BCAST_I,        // Send as broadcast
    input  wire logic [7:0]  SRC_EP_I,       // Own source endpoint
    input  wire logic        EXPLICIT_EN_I,  // Explicit output enabled
    output logic             BUSY_O,         // Command in flight
    output logic             IND_VALID_O,    // Pulse: receive indication ready
    output logic [7:0]       IND_CODE_O,     // Response code
    output logic [7:0]       IND_STATUS_O,   // Response status
    output logic [15:0]      IND_BLOCK_O,    // Response block field
    output logic [15:0]      IND_OFFSET_O,   // Response offset field
    output logic [15:0]      IND_COUNT_O     // Response count field
);
    // ****************************************************************
    // Send header, collect reply
    // ****************************************************************
    store_cmd_pkg::xfer_state_t st_q, st_d;
    logic [3:0]  idx_q, idx_d;
    logic [7:0]  rx_q [8];
    logic [7:0]  rx_d [8];
    logic [7:0]  tx_q [8];
    logic [7:0]  tx_d [8];
    logic        ind_q, ind_d;
    logic        bc_q, bc_d;

    assign LINK.req_valid   = (st_q == store_cmd_pkg::ST_HDR);
    assign LINK.req_byte    = tx_q[idx_q[2:0]];
    assign LINK.req_last    = (idx_q == 4'h7);
    assign LINK.req_bcast   = bc_q;
    assign LINK.req_src_ep  = SRC_EP_I;
    assign LINK.req_cluster = `STORE_CLUSTER;
    assign LINK.req_dst_ep  = `STORE_ENDPOINT;
    assign LINK.rsp_ready   = (st_q == store_cmd_pkg::ST_WAIT);
    assign BUSY_O = (st_q != store_cmd_pkg::ST_IDLE);
    assign IND_VALID_O  = ind_q;
    assign IND_CODE_O   = rx_q[0];
    assign IND_STATUS_O = rx_q[1];
    assign IND_BLOCK_O  = {rx_q[2], rx_q[3]};
    assign IND_OFFSET_O = {rx_q[4], rx_q[5]};
    assign IND_COUNT_O  = {rx_q[6], rx_q[7]};

    // Next-state logic
    always_comb begin
        st_d = st_q;
        idx_d = idx_q;
        ind_d = 1'b0;
        bc_d = bc_q;
        for (int i = 0; i < 8; i++) begin
            rx_d[i] = rx_q[i];
            tx_d[i] = tx_q[i];
        end
        case (st_q)
            store_cmd_pkg::ST_IDLE: begin
                if (START_I) begin
                    // Geometry query forces all other fields zero
                    tx_d[0] = CODE_I;
                    tx_d[1] = 8'h00;
                    tx_d[2] = (CODE_I == `CMD_GEOMETRY_Q) ? 8'h00 : BLOCK_I[15:8];
                    tx_d[3] = (CODE_I == `CMD_GEOMETRY_Q) ? 8'h00 : BLOCK_I[7:0];
                    tx_d[4] = (CODE_I == `CMD_GEOMETRY_Q) ? 8'h00 : OFFSET_I[15:8];
                    tx_d[5] = (CODE_I == `CMD_GEOMETRY_Q) ? 8'h00 : OFFSET_I[7:0];
                    tx_d[6] = 8'h00;
                    tx_d[7] = 8'h00;
                    bc_d = BCAST_I;
                    idx_d = 4'h0;
                    st_d = store_cmd_pkg::ST_HDR;
                end
            end
            store_cmd_pkg::ST_HDR: begin
                if (LINK.req_ready) begin
                    idx_d = idx_q + 4'h1;
                    if (idx_q == 4'h7) begin
                        idx_d = 4'h0;
                        st_d = bc_q ? store_cmd_pkg::ST_IDLE : store_cmd_pkg::ST_WAIT;
                    end
                end
            end
            store_cmd_pkg::ST_WAIT: begin
                if (LINK.rsp_valid) begin
                    rx_d[idx_q[2:0]] = LINK.rsp_byte;
                    idx_d = idx_q + 4'h1;
                    if (LINK.rsp_last) begin
                        idx_d = 4'h0;
                        st_d = store_cmd_pkg::ST_IDLE;
                        // Indicate only when addressed to store endpoint or explicit
                        ind_d = (LINK.rsp_dst_ep == `STORE_ENDPOINT) || EXPLICIT_EN_I;
                    end
                end
            end
            default: st_d = store_cmd_pkg::ST_IDLE;
        endcase
    end

    // Register stage
    always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            st_q <= store_cmd_pkg::ST_IDLE;
            idx_q <= 4'h0;
            ind_q <= 1'b0;
            bc_q <= 1'b0;
            for (int i = 0; i < 8; i++) begin
                rx_q[i] <= 8'h00;
                tx_q[i] <= 8'h00;
            end
        end else begin
            st_q <= st_d;
            idx_q <= idx_d;
            ind_q <= ind_d;
            bc_q <= bc_d;
            for (int i = 0; i < 8; i++) begin
                rx_q[i] <= rx_d[i];
                tx_q[i] <= tx_d[i];
            end
        end
    end
endmodule

// File: hw/store_link_if.sv
`timescale 1ns/1ns
// Byte stream in each direction, one byte per valid&ready beat
interface store_link_if;
    logic       req_valid;
    logic       req_ready;
    logic [7:0] req_byte;
    logic       req_last;
    logic       req_bcast;
    logic [7:0] req_src_ep;
    logic [15:0] req_cluster;
    logic [7:0] req_dst_ep;
    logic       rsp_valid;
    logic       rsp_ready;
    logic [7:0] rsp_byte;
    logic       rsp_last;
    logic [7:0] rsp_dst_ep;
    modport device (input req_valid, req_byte, req_last, req_bcast, req_src_ep,
                    req_cluster, req_dst_ep, rsp_ready,
                    output req_ready, rsp_valid, rsp_byte, rsp_last, rsp_dst_ep);
    modport requester (output req_valid, req_byte, req_last, req_bcast, req_src_ep,
                       req_cluster, req_dst_ep, rsp_ready,
                       input req_ready, rsp_valid, rsp_byte, rsp_last, rsp_dst_ep);
endinterface

// File: verif/flash_store_command_handler_tb.sv
`timescale 1ns/1ns
module flash_store_command_handler_tb;
    // ****************************************
    // Both ends joined, user sides driven here
    // ****************************************
    logic        clk, rst_n, start, bcast, expl, fw_set;
    logic [7:0]  code, src;
    logic [15:0] blk, off;
    logic [31:0] seed = 32'h00000062;
    logic [63:0] expq [$];
    int          errors, total_checks, i;
    wire         busy, ind_v, done, fw_busy;
    wire [7:0]   i_code, i_stat;
    wire [15:0]  i_blk, i_off, i_cnt;
    store_link_if lnk();
    store_cmd_device #(.NUM_BLOCKS(119)) i_store_cmd_device (.SYS_CLK_I(clk),
        .RESETN_I(rst_n), .LINK(lnk), .FW_SLOT_BUSY_O(fw_busy), .FW_SLOT_SET_I(fw_set),
        .CMD_DONE_O(done));
    store_cmd_requester i_store_cmd_requester (.SYS_CLK_I(clk), .RESETN_I(rst_n),
        .LINK(lnk), .START_I(start), .CODE_I(code), .BLOCK_I(blk), .OFFSET_I(off),
        .BCAST_I(bcast), .SRC_EP_I(src), .EXPLICIT_EN_I(expl), .BUSY_O(busy),
        .IND_VALID_O(ind_v), .IND_CODE_O(i_code), .IND_STATUS_O(i_stat),
        .IND_BLOCK_O(i_blk), .IND_OFFSET_O(i_off), .IND_COUNT_O(i_cnt));
    store_link_checker #(.NUM_BLOCKS(119)) i_store_link_checker (.SYS_CLK_I(clk),
        .RESETN_I(rst_n), .req_valid(lnk.req_valid), .req_ready(lnk.req_ready),
        .req_byte(lnk.req_byte), .req_last(lnk.req_last), .req_bcast(lnk.req_bcast),
        .req_src_ep(lnk.req_src_ep), .req_cluster(lnk.req_cluster),
        .req_dst_ep(lnk.req_dst_ep), .rsp_valid(lnk.rsp_valid), .rsp_ready(lnk.rsp_ready),
        .rsp_byte(lnk.rsp_byte), .rsp_last(lnk.rsp_last), .rsp_dst_ep(lnk.rsp_dst_ep));
    // Free-running clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] t;
        t = v ^ (v << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic end_of_test();
        if (errors == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // One command from a falling edge; the watch ends after three idle cycles
    task automatic run_cmd(input int idx);
        int          w, q, nd;
        logic        bad;
        logic [63:0] ev;
        seed = xs(seed);
        code = (idx < 7) ? idx[7:0] : (idx == 7) ? 8'hff : {5'h00, seed[2:0]};
        blk = (code == 8'h00) ? 16'h0000 : (idx == 1) ? 16'h0076 : (idx == 2) ? 16'h0077
            : {9'h000, seed[14:8]};
        off = (code == 8'h00) ? 16'h0000 : seed[31:16];
        bcast = idx > 7 && seed[3];
        src = (idx < 4 || seed[4]) ? 8'he6 : seed[23:16];
        expl = seed[5];
        start = 1'b1;
        bad = code > 8'h04 || (code != 8'h00 && blk >= 16'h0077);
        ev = {code | 8'h80, 7'h00, bad, (code == 8'h00) ? 32'h00770200 : {blk, off}, 16'h0000};
        if (!bcast && (src == 8'he6 || expl)) expq.push_back(ev);
        @(negedge clk);
        start = 1'b0;
        q = 0;
        nd = 0;
        for (w = 0; w < 60 && q < 3; w++) begin
            q = (busy === 1'b0) ? q + 1 : 0;
            if (done === 1'b1) nd++;
            if (ind_v === 1'b1 && expq.size() == 0) chk("stray ind", 64'h0, 64'h1);
            else if (ind_v === 1'b1) chk("ind", expq.pop_front(), {i_code, i_stat, i_blk, i_off, i_cnt});
            @(negedge clk);
        end
        if (q < 3) begin
            errors++;
            end_of_test();
        end
        chk("done", 64'h1, nd);
        chk("missing ind", 64'h0, expq.size());
    endtask
    // Main sequence
    initial begin
        rst_n = 1'b0;
        start = 1'b0;
        fw_set = 1'b0;
        code = 8'h00;
        blk = 16'h0000;
        off = 16'h0000;
        bcast = 1'b0;
        src = 8'he6;
        expl = 1'b0;
        // Reset held for six cycles, released off the sampling edge
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        expq.delete();
        chk("fw", 64'h0, fw_busy);
        for (i = 0; i < 12; i++) run_cmd(i);
        fw_set = 1'b1;
        @(negedge clk);
        fw_set = 1'b0;
        for (i = 12; i < 24; i++) run_cmd(i);
        chk("fw", 64'h1, fw_busy);
        rst_n = 1'b0;
        @(negedge clk);
        rst_n = 1'b1;
        chk("fw", 64'h0, fw_busy);
        run_cmd(0);
        end_of_test();
    end
endmodule

// File: verif/store_link_checker.sv
`timescale 1ns/1ns
`include "store_cmd_defs.svh"
module store_link_checker #(
    parameter int NUM_BLOCKS = 119
) (
    input wire logic        SYS_CLK_I,   // Clock
    input wire logic        RESETN_I,    // Async reset, active low
    input wire logic        req_valid,   // Request byte valid
    input wire logic        req_ready,   // Device takes byte
    input wire logic [7:0]  req_byte,    // Request byte
    input wire logic        req_last,    // Last request byte
    input wire logic        req_bcast,   // Broadcast frame
    input wire logic [7:0]  req_src_ep,  // Source endpoint
    input wire logic [15:0] req_cluster, // Target cluster
    input wire logic [7:0]  req_dst_ep,  // Target endpoint
    input wire logic        rsp_valid,   // Response byte valid
    input wire logic        rsp_ready,   // Requester takes byte
    input wire logic [7:0]  rsp_byte,    // Response byte
    input wire logic        rsp_last,    // Last response byte
    input wire logic [7:0]  rsp_dst_ep   // Response endpoint
);
    // ****************************************
    // Frame tracking
    // ****************************************
    logic [7:0]  rq_q [8];
    logic [3:0]  ri_q;
    logic [3:0]  si_q;
    logic [7:0]  sep_q;
    logic [15:0] blk;
    logic        bad;
    logic [63:0] exp_v;
    wire         take = req_valid && req_ready;
    // Byte indices and the endpoint that the answer must go back to
    always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            ri_q  <= 4'h0;
            si_q  <= 4'h0;
            sep_q <= 8'h00;
        end else begin
            if (take) ri_q <= req_last ? 4'h0 : ri_q + {3'h0, ri_q < 4'h8};
            if (take && req_last) sep_q <= req_src_ep;
            if (rsp_valid && rsp_ready) si_q <= rsp_last ? 4'h0 : si_q + 4'h1;
        end
    end
    // No reset: only read while an answer is out, bytes past the eighth dropped
    always_ff @(posedge SYS_CLK_I) begin
        if (take && ri_q < 4'h8) rq_q[ri_q[2:0]] <= req_byte;
    end
    // Expected answer, most significant byte of each field first
    always_comb begin
        blk = {rq_q[2], rq_q[3]};
        bad = rq_q[0] > `CMD_LAST_VALID || (rq_q[0] != `CMD_GEOMETRY_Q && blk >= NUM_BLOCKS);
        exp_v = {rq_q[0] | `CMD_REPLY_BIT, 7'h00, bad, blk, rq_q[4], rq_q[5], 16'h0000};
        if (rq_q[0] == `CMD_GEOMETRY_Q) exp_v[47:16] = {16'(NUM_BLOCKS), `STORE_BLOCK_BYTES};
    end
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (!RESETN_I);
    property p_answer; take && req_last && !req_bcast |=> rsp_valid; endproperty
    a_answer: assert property (p_answer) else $error("no answer");
    property p_quiet; take && req_last && req_bcast |=> !rsp_valid [*8]; endproperty
    a_quiet: assert property (p_quiet) else $error("broadcast answered");
    property p_dst; rsp_valid |-> rsp_dst_ep == sep_q; endproperty
    a_dst: assert property (p_dst) else $error("answer endpoint");
    property p_byte; rsp_valid |-> rsp_byte == exp_v[8*(7-si_q[2:0]) +: 8]; endproperty
    a_byte: assert property (p_byte) else $error("answer byte");
    property p_status; rsp_valid && si_q == 4'h1 |-> rsp_byte == {7'h00, bad}; endproperty
    a_status: assert property (p_status) else $error("status byte");
    property p_last; rsp_valid |-> rsp_last == (si_q == 4'h7); endproperty
    a_last: assert property (p_last) else $error("answer length");
    property p_len; $rose(rsp_valid) |-> ##[7:40] (rsp_ready && rsp_last); endproperty
    a_len: assert property (p_len) else $error("answer unfinished");
    property p_addr;
        req_valid |-> req_cluster == `STORE_CLUSTER && req_dst_ep == `STORE_ENDPOINT;
    endproperty
    a_addr: assert property (p_addr) else $error("frame address");
endmodule
